// file: rcd_pkg.sv
// Summary of operation
// [R1] At each reset every cause flag whose source was active is set and every other one cleared.
// [R2] A reset forced by the debug host through the force bit leaves all cause flags cleared.
// [R3] A write to the cause flags address in the RCD_RUN state clears the watchdog counter and leaves the flags alone.
// [R4] After power-on the power-on flag (bit 7) and the low-voltage flag (bit 1) are set, others clear.
// [R5] After a low-voltage reset the power-on flag is kept, the low-voltage flag set, the rest cleared.
// [R6] Bit 6 is set when the reset came from a low level on the external reset input.
// [R7] Bit 5 is set on a watchdog timeout reset, and no such reset happens while the enable is 0.
// [R8] Bit 4 is set when reset came from an attempt to run an unimplemented or illegal instruction.
// [R9] Stop is illegal while stop is disabled, background entry is illegal while debug mode is off.
// [R10] Bit 2 is set when the clock generation module requested the reset.
// [R11] A low-voltage reset, with bit 1 set, happens only with both its enables set and a trip.
// [R12] The force register has one write-only bit in bit 0 and always reads as zero.
// [R13] User program writes to the force register are ignored; only background writes reach it.
// [R14] The debug host writing one to the force bit resets the whole chip, writing zero does nothing.
// [R15] The watchdog enable that gates watchdog resets is one after reset and zero disables it.
// [R16] Cause flags are captured at reset release and stay stable until the next reset.
package rcd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] RCD_FLAGS_ADDR = 16'h1800;
    localparam logic [15:0] RCD_FORCE_ADDR = 16'h1801;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int RCD_BIT_POR   = 7;
    localparam int RCD_BIT_PIN   = 6;
    localparam int RCD_BIT_WDOG  = 5;
    localparam int RCD_BIT_ILLEGAL_OPCODE_FLAG  = 4;
    localparam int RCD_BIT_CLK   = 2;
    localparam int RCD_BIT_LVD   = 1;
    localparam int RCD_BIT_FORCE = 0;

    localparam logic [7:0] RCD_FLAGS_POR_VAL = 8'h82;
    localparam logic [7:0] RCD_ZERO_BYTE     = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RCD_CLK_PERIOD_NS = 50;
    localparam int RCD_RESET_HOLD_NS = 1600;
    localparam int RCD_RESET_HOLD_CYC =
        (RCD_RESET_HOLD_NS + RCD_CLK_PERIOD_NS - 1) / RCD_CLK_PERIOD_NS;

    typedef enum logic {
        RCD_RUN,
        RCD_HOLD
    } rcd_state_t;

endpackage

// file: rcd_reset_cause.sv
`timescale 1ns/1ps
module rcd_reset_cause
    import rcd_pkg::*;
#(
    parameter int HOLD_CYC = RCD_RESET_HOLD_CYC
) (
    input  logic        ref_clk,
    input  logic        rst,
    input  logic        pin_reset_n,
    input  logic        watchdog_timeout,
    input  logic        watchdog_enable,
    input  logic        illegal_opcode,
    input  logic        stop_exec,
    input  logic        stop_enable,
    input  logic        background_entry_instruction_exec,
    input  logic        background_mode_enable,
    input  logic        clock_module_reset_req,
    input  logic        low_voltage_trip,
    input  logic        low_voltage_reset_enable,
    input  logic        low_voltage_stop_enable,
    input  logic        bus_wr,
    input  logic        bus_rd,
    input  logic        bus_from_debug,
    input  logic [15:0] bus_addr,
    input  logic [7:0]  bus_wdata,
    output logic [7:0]  bus_rdata_r,
    output logic        watchdog_clear_r,
    output logic        system_reset_r,
    output logic [7:0]  reset_cause_flags_r
);

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    logic       wdog_req;
    logic       illegal_opcode_flag_req;
    logic       lvr_req;
    logic       force_req;
    logic       any_req;
    logic       sel_flags;
    logic       sel_force;
    logic [7:0] cause_now;

    assign sel_flags = (bus_addr == RCD_FLAGS_ADDR);
    assign sel_force = (bus_addr == RCD_FORCE_ADDR);

    assign wdog_req  = watchdog_timeout & watchdog_enable;                 // R7 R15
    assign illegal_opcode_flag_req  = illegal_opcode                                      // R8
                     | (stop_exec & ~stop_enable)                          // R9
                     | (background_entry_instruction_exec & ~background_mode_enable);              // R9
    assign lvr_req   = low_voltage_trip & low_voltage_reset_enable
                     & low_voltage_stop_enable;                            // R11
    assign force_req = bus_wr & bus_from_debug & sel_force
                     & bus_wdata[RCD_BIT_FORCE];                           // R13 R14
    assign any_req   = ~pin_reset_n | wdog_req | illegal_opcode_flag_req | clock_module_reset_req
                     | lvr_req | force_req;

    // Force request contributes no flag of its own
    always_comb begin
        cause_now               = RCD_ZERO_BYTE;                           // R2
        cause_now[RCD_BIT_PIN]  = ~pin_reset_n;                            // R6
        cause_now[RCD_BIT_WDOG] = wdog_req;                                // R7
        cause_now[RCD_BIT_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag_req;                                // R8
        cause_now[RCD_BIT_CLK]  = clock_module_reset_req;                  // R10
        cause_now[RCD_BIT_LVD]  = lvr_req;                                 // R11
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    rcd_state_t  state_r;
    logic [15:0] hold_cnt_r;
    logic [7:0]  pending_r;
    logic        release_now;

    assign release_now = (state_r == RCD_HOLD) && (hold_cnt_r == 16'h0000)
                       && pin_reset_n && !lvr_req;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= RCD_RUN;
        end else begin
            case (state_r)
                RCD_RUN: begin
                    if (any_req) begin
                        state_r <= RCD_HOLD;                               // R14
                    end
                end
                RCD_HOLD: begin
                    if (release_now) begin
                        state_r <= RCD_RUN;
                    end
                end
                default: begin
                    state_r <= RCD_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_cnt_r <= 16'h0000;
        end else if (state_r == RCD_RUN) begin
            hold_cnt_r <= 16'(HOLD_CYC - 1);
        end else if (hold_cnt_r != 16'h0000) begin
            hold_cnt_r <= hold_cnt_r - 16'h0001;
        end
    end

    // Sources seen during the reset, up to the cycle before its release, are gathered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pending_r <= RCD_ZERO_BYTE;
        end else if (state_r == RCD_RUN) begin
            if (any_req) begin
                pending_r <= cause_now;                                    // R1
            end
        end else if (!release_now) begin
            pending_r <= pending_r | cause_now;                            // R1
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            system_reset_r <= 1'b0;
        end else begin
            system_reset_r <= (state_r == RCD_RUN) ? any_req : !release_now;   // R14
        end
    end

    // ------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reset_cause_flags_r <= RCD_FLAGS_POR_VAL;                      // R4
        end else if (release_now) begin
            reset_cause_flags_r <= pending_r;                              // R1 R16
            reset_cause_flags_r[RCD_BIT_POR] <=
                pending_r[RCD_BIT_LVD] & reset_cause_flags_r[RCD_BIT_POR]; // R5
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            watchdog_clear_r <= 1'b0;
        end else begin
            watchdog_clear_r <= bus_wr && sel_flags && (state_r == RCD_RUN);   // R3
        end
    end

    // Force register and unmapped addresses read as zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_rdata_r <= RCD_ZERO_BYTE;
        end else if (bus_rd && sel_flags) begin
            bus_rdata_r <= reset_cause_flags_r;
        end else begin
            bus_rdata_r <= RCD_ZERO_BYTE;                                  // R12
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic first_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Length of the running reset pulse, saturating
    localparam logic [15:0] HOLD_LEN = 16'(HOLD_CYC);

    logic [15:0] hi_cnt_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hi_cnt_r <= 16'h0000;
        end else if (!system_reset_r) begin
            hi_cnt_r <= 16'h0000;
        end else if (hi_cnt_r != 16'hffff) begin
            hi_cnt_r <= hi_cnt_r + 16'h0001;
        end
    end

    sequence enter_s;
        (state_r == RCD_RUN) && any_req;
    endsequence

    sequence held_s;
        system_reset_r [*8];
    endsequence

    sequence release_s;
        $fell(system_reset_r);
    endsequence

    por_flags_a: assert property (@(posedge ref_clk) disable iff (rst)   // R4
        first_r |-> (reset_cause_flags_r == RCD_FLAGS_POR_VAL) && !system_reset_r)
        else $error("power-on flags wrong");

    reset_hold_a: assert property (@(posedge ref_clk) disable iff (rst)  // R14
        enter_s |=> held_s)
        else $error("reset not held");

    user_force_a: assert property (@(posedge ref_clk) disable iff (rst)  // R13
        (state_r == RCD_RUN) && bus_wr && sel_force && !bus_from_debug
        && pin_reset_n && !wdog_req && !illegal_opcode_flag_req && !clock_module_reset_req
        && !lvr_req |=> !system_reset_r)
        else $error("user write forced reset");

    wdog_clear_a: assert property (@(posedge ref_clk) disable iff (rst)  // R3
        (state_r == RCD_RUN) && bus_wr && sel_flags
        |=> watchdog_clear_r && $stable(reset_cause_flags_r))
        else $error("status write misbehaved");

    flags_stable_a: assert property (@(posedge ref_clk) disable iff (rst) // R16
        !release_now |=> $stable(reset_cause_flags_r))
        else $error("flags changed outside release");

    release_flags_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
        release_s |-> (reset_cause_flags_r[6:0] == $past(pending_r[6:0])))
        else $error("flags differ from causes");

    lvr_flags_a: assert property (@(posedge ref_clk) disable iff (rst)   // R5
        release_s ##0 $past(pending_r[RCD_BIT_LVD]) |->
        reset_cause_flags_r[RCD_BIT_LVD]
        && (reset_cause_flags_r[RCD_BIT_POR] == $past(reset_cause_flags_r[RCD_BIT_POR])))
        else $error("low-voltage release wrong");

    force_only_a: assert property (@(posedge ref_clk) disable iff (rst)  // R2
        release_s ##0 ($past(pending_r) == RCD_ZERO_BYTE) |->
        (reset_cause_flags_r == RCD_ZERO_BYTE))
        else $error("forced reset left a flag");

    force_read_a: assert property (@(posedge ref_clk) disable iff (rst)  // R12
        bus_rd && sel_force |=> (bus_rdata_r == RCD_ZERO_BYTE))
        else $error("force register read nonzero");

    wdog_gate_a: assert property (@(posedge ref_clk) disable iff (rst)   // R7
        (state_r == RCD_RUN) && watchdog_timeout && !watchdog_enable && pin_reset_n
        && !illegal_opcode_flag_req && !clock_module_reset_req && !lvr_req && !force_req
        |=> !system_reset_r)
        else $error("disabled watchdog reset");

    stop_illegal_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
        (state_r == RCD_RUN) && stop_exec && !stop_enable
        |=> system_reset_r && pending_r[RCD_BIT_ILLEGAL_OPCODE_FLAG])
        else $error("illegal stop not reset");

    reset_len_a: assert property (@(posedge ref_clk) disable iff (rst)   // R14
        release_s |-> (hi_cnt_r >= HOLD_LEN))
        else $error("reset pulse too short");

    pin_enter_a: assert property (@(posedge ref_clk) disable iff (rst)   // R6
        (state_r == RCD_RUN) && !pin_reset_n
        |=> system_reset_r && pending_r[RCD_BIT_PIN])
        else $error("pin reset not taken");

    pin_hold_a: assert property (@(posedge ref_clk) disable iff (rst)    // R6
        system_reset_r && !pin_reset_n |=> system_reset_r)
        else $error("reset released while pin low");

    wdog_enter_a: assert property (@(posedge ref_clk) disable iff (rst)  // R7
        (state_r == RCD_RUN) && watchdog_timeout && watchdog_enable
        |=> system_reset_r && pending_r[RCD_BIT_WDOG])
        else $error("watchdog reset not taken");

    illegal_opcode_flag_enter_a: assert property (@(posedge ref_clk) disable iff (rst)  // R8
        (state_r == RCD_RUN) && illegal_opcode
        |=> system_reset_r && pending_r[RCD_BIT_ILLEGAL_OPCODE_FLAG])
        else $error("illegal opcode reset not taken");

    background_entry_instruction_illegal_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
        (state_r == RCD_RUN) && background_entry_instruction_exec && !background_mode_enable
        |=> system_reset_r && pending_r[RCD_BIT_ILLEGAL_OPCODE_FLAG])
        else $error("illegal background entry not reset");

    clk_enter_a: assert property (@(posedge ref_clk) disable iff (rst)   // R10
        (state_r == RCD_RUN) && clock_module_reset_req
        |=> system_reset_r && pending_r[RCD_BIT_CLK])
        else $error("clock module reset not taken");

    lvr_gate_a: assert property (@(posedge ref_clk) disable iff (rst)    // R11
        (state_r == RCD_RUN) && low_voltage_trip
        && !(low_voltage_reset_enable && low_voltage_stop_enable) && pin_reset_n
        && !wdog_req && !illegal_opcode_flag_req && !clock_module_reset_req && !force_req
        |=> !system_reset_r)
        else $error("gated low-voltage reset");

    force_enter_a: assert property (@(posedge ref_clk) disable iff (rst) // R14
        (state_r == RCD_RUN) && force_req |=> system_reset_r)
        else $error("forced reset not taken");

    read_idle_a: assert property (@(posedge ref_clk) disable iff (rst)   // R12
        !(bus_rd && sel_flags) |=> (bus_rdata_r == RCD_ZERO_BYTE))
        else $error("read data not zero");

    flags_read_a: assert property (@(posedge ref_clk) disable iff (rst)  // R16
        bus_rd && sel_flags |=> (bus_rdata_r == $past(reset_cause_flags_r)))
        else $error("flags read wrong");

endmodule // rcd_reset_cause

// file: rcd_host.sv
`timescale 1ns/1ps
module rcd_host (
    input  wire logic        ref_clk,
    input  wire logic [7:0]  bus_rdata_r,
    input  wire logic        watchdog_clear_r,
    output logic      [6:0]  src_r,
    output logic      [4:0]  en_r,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic             bus_from_debug,
    output logic      [15:0] bus_addr,
    output logic      [7:0]  bus_wdata
);
    logic [7:0] rd_r;
    logic       clr_r;

    initial begin
        src_r = 7'h00;
        en_r = 5'h19;
        bus_wr = 1'h0;
        bus_rd = 1'h0;
        bus_from_debug = 1'h0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
    end

    // ------------------------------------------------------------
    // Byte access, answer taken one edge later
    // ------------------------------------------------------------
    task automatic acc(input logic wr, input logic dbg, input logic [15:0] a,
                       input logic [7:0] d);
        @(negedge ref_clk);
        bus_wr = wr;
        bus_rd = ~wr;
        bus_from_debug = dbg;
        bus_addr = a;
        bus_wdata = d;
        @(negedge ref_clk);
        rd_r = bus_rdata_r;
        clr_r = watchdog_clear_r;
        bus_wr = 1'h0;
        bus_rd = 1'h0;
        bus_from_debug = 1'h0;
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask

    // Pulse of one reset source over three edges
    task automatic fire(input int i);
        @(negedge ref_clk);
        src_r[i] = 1'h1;
        repeat (3) @(negedge ref_clk);
        src_r[i] = 1'h0;
    endtask
endmodule // rcd_host

// file: rcd_reset_cause_test.sv
`timescale 1ns/1ps
module rcd_reset_cause_test;
    import rcd_pkg::*;

    logic        ref_clk = 1'h0;
    logic        rst = 1'h1;
    wire  [6:0]  src;
    wire  [4:0]  en;
    wire         wr, rd, dbg, wclr, sysrst;
    wire  [15:0] addr;
    wire  [7:0]  wdata, rdata, flags;
    int          num_errors = 0;
    int          n_checks = 0;
    int          t_src[15] = '{6, 0, 6, 1, 1, 5, 3, 5, 3, 4, 5, 4, 2, 6, 6};
    logic [4:0]  t_en[15] = '{5'h19, 5'h19, 5'h19, 5'h19, 5'h18, 5'h19, 5'h19, 5'h19,
                              5'h1b, 5'h19, 5'h19, 5'h1d, 5'h19, 5'h09, 5'h11};
    logic        t_go[15] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1,
                              1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
    logic [7:0]  t_exp[15] = '{8'h82, 8'h40, 8'h02, 8'h20, 8'h20, 8'h04, 8'h10, 8'h04,
                               8'h04, 8'h10, 8'h04, 8'h04, 8'h10, 8'h10, 8'h10};

    always #25 ref_clk = ~ref_clk;

    rcd_host host (.ref_clk(ref_clk), .bus_rdata_r(rdata), .watchdog_clear_r(wclr),
        .src_r(src), .en_r(en), .bus_wr(wr), .bus_rd(rd), .bus_from_debug(dbg),
        .bus_addr(addr), .bus_wdata(wdata));

    rcd_reset_cause dut (.ref_clk(ref_clk), .rst(rst),
        .pin_reset_n(~src[0]), .watchdog_timeout(src[1]), .watchdog_enable(en[0]),
        .illegal_opcode(src[2]), .stop_exec(src[3]), .stop_enable(en[1]),
        .background_entry_instruction_exec(src[4]), .background_mode_enable(en[2]),
        .clock_module_reset_req(src[5]), .low_voltage_trip(src[6]),
        .low_voltage_reset_enable(en[3]), .low_voltage_stop_enable(en[4]),
        .bus_wr(wr), .bus_rd(rd), .bus_from_debug(dbg), .bus_addr(addr),
        .bus_wdata(wdata), .bus_rdata_r(rdata), .watchdog_clear_r(wclr),
        .system_reset_r(sysrst), .reset_cause_flags_r(flags));

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Waits out any reset, then reads back the cause flags
    task automatic settle(input logic go, input logic [7:0] e);
        repeat (4) if (sysrst !== 1'h1) @(negedge ref_clk);
        cmp_bit("reset entered", go, sysrst);
        repeat (60) if (sysrst === 1'h1) @(negedge ref_clk);
        cmp_bit("reset released", 1'h0, sysrst);
        host.acc(1'h0, 1'h0, RCD_FLAGS_ADDR, 8'h00);
        cmp_byte("flags read", e, host.rd_r);
        cmp_byte("flags port", e, flags);
        $display("case done, flags %h", flags);
    endtask

    initial begin
        #200000;
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (10) @(negedge ref_clk);
        rst = 1'h0;
        cmp_byte("power-on flags", RCD_FLAGS_POR_VAL, flags);
        for (int k = 0; k < 15; k++) begin
            host.en_r = t_en[k];
            host.fire(t_src[k]);
            settle(t_go[k], t_exp[k]);
        end
        host.acc(1'h0, 1'h0, RCD_FORCE_ADDR, 8'h00);
        cmp_byte("force read", RCD_ZERO_BYTE, host.rd_r);
        host.acc(1'h0, 1'h0, 16'h1810, 8'h00);
        cmp_byte("unmapped read", RCD_ZERO_BYTE, host.rd_r);
        host.acc(1'h1, 1'h0, RCD_FLAGS_ADDR, 8'hff);
        cmp_bit("watchdog clear", 1'h1, host.clr_r);
        host.acc(1'h1, 1'h0, RCD_FORCE_ADDR, 8'h01);
        cmp_bit("clear one cycle", 1'h0, host.clr_r);
        $display("register access case done");
        settle(1'h0, 8'h10);
        host.acc(1'h1, 1'h1, RCD_FORCE_ADDR, 8'h00);
        settle(1'h0, 8'h10);
        host.acc(1'h1, 1'h1, RCD_FORCE_ADDR, 8'h01);
        settle(1'h1, RCD_ZERO_BYTE);
        rst = 1'h1;
        repeat (2) @(negedge ref_clk);
        rst = 1'h0;
        settle(1'h0, RCD_FLAGS_POR_VAL);
        complete_run();
    end
endmodule // rcd_reset_cause_test
